// ### sdram_cmd_defines.vh
/*
 * Shared constants for the DRAM command and bank logic: command codes,
 * address field positions, reset values and timing counts.
 * Assumes a 125 MHz core clock (8 ns period).
 */
`ifndef SDRAM_CMD_DEFINES_VH
`define SDRAM_CMD_DEFINES_VH

// ----------------------------------------------------------------
// Clock
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 8

// ----------------------------------------------------------------
// Commands, encoded as {row strobe, column strobe, write enable}
// ----------------------------------------------------------------
`define CMD_MODE_SET 3'h0
`define CMD_REFRESH 3'h1
`define CMD_PRECHARGE 3'h2
`define CMD_ACTIVATE 3'h3
`define CMD_WRITE 3'h4
`define CMD_READ 3'h5
`define CMD_CALIBRATE 3'h6
`define CMD_NOP 3'h7

// ----------------------------------------------------------------
// Address and data layout
// ----------------------------------------------------------------
`define ADDR_W 16
`define ROW_W 16
`define BANK_W 3
`define NUM_BANKS 8
`define DATA_W 16
`define MASK_W 2
`define AUTO_CLOSE_BIT 10
`define BURST_SEL_BIT 12
`define MEM_COL_W 6
`define MEM_DEPTH 512

// ----------------------------------------------------------------
// Impedance calibration
// ----------------------------------------------------------------
`define IMP_W 6
`define RON_RESET 6'h20
`define RTT_RESET 6'h20
`define SHORT_CAL_CYCLES 10'd64
`define INIT_CAL_CYCLES 10'd512
`define OPER_CAL_CYCLES 10'd256

// ----------------------------------------------------------------
// Bank and refresh timing
// ----------------------------------------------------------------
`define PRECHARGE_TIME_NS 15
`define PRECHARGE_CYCLES ((`PRECHARGE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REFRESH_TIME_NS 160
`define REFRESH_CYCLES ((`REFRESH_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TIMER_W 8

`endif

// ### bank_tracker.v
/*
 * State of one DRAM bank: idle or open row, row address and precharge timer.
 * Assumes one-cycle activate and precharge strobes from the command decoder.
 */
`timescale 1ns/10ps
`include "sdram_cmd_defines.vh"

module bank_tracker (
    // Clock and reset
    input wire core_clk,
    input wire rst,
    // Strobes
    input wire activate,
    input wire precharge,
    input wire [`ROW_W-1:0] row_in,
    // State
    output reg open_reg,
    output reg [`ROW_W-1:0] row_reg,
    output reg precharging_reg
);

reg [`TIMER_W-1:0] timer_reg;
wire [31:0] pre_count;

assign pre_count = `PRECHARGE_CYCLES;

always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        open_reg <= 1'b0;
        row_reg <= {`ROW_W{1'b0}};
        precharging_reg <= 1'b0;
        timer_reg <= {`TIMER_W{1'b0}};
    end else if (precharge) begin
        // Closes the row; timer restarts even if already idle
        open_reg <= 1'b0;
        precharging_reg <= 1'b1;
        timer_reg <= pre_count[`TIMER_W-1:0];
    end else if (activate && !open_reg && !precharging_reg) begin
        open_reg <= 1'b1;
        row_reg <= row_in;
    end else if (precharging_reg) begin
        timer_reg <= timer_reg - 1'b1;
        if (timer_reg == {{(`TIMER_W-1){1'b0}}, 1'b1}) begin
            precharging_reg <= 1'b0;
        end
    end
end

endmodule // bank_tracker

// ### impedance_calibrator.v
/*
 * Impedance calibration engine for the output driver and termination.
 * Assumes the target codes come from the calibration pin comparator.
 */
`timescale 1ns/10ps
`include "sdram_cmd_defines.vh"

module impedance_calibrator (
    // Clock and reset
    input wire core_clk,
    input wire rst,
    // Commands
    input wire long_cal,
    input wire short_cal,
    input wire [`IMP_W-1:0] target_ron,
    input wire [`IMP_W-1:0] target_rtt,
    // Results
    output reg busy_reg,
    output reg [`IMP_W-1:0] ron_reg,
    output reg [`IMP_W-1:0] rtt_reg
);

reg [9:0] count_reg;
reg is_long_reg;
reg init_done_reg;

function [`IMP_W-1:0] step_toward;
    input [`IMP_W-1:0] cur;
    input [`IMP_W-1:0] tgt;
    begin
        if (cur < tgt) begin
            step_toward = cur + 1'b1;
        end else if (cur > tgt) begin
            step_toward = cur - 1'b1;
        end else begin
            step_toward = cur;
        end
    end
endfunction

always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        busy_reg <= 1'b0;
        count_reg <= 10'h000;
        is_long_reg <= 1'b0;
        init_done_reg <= 1'b0;
        ron_reg <= `RON_RESET;
        rtt_reg <= `RTT_RESET;
    end else if (!busy_reg) begin
        if (long_cal) begin
            // First long run uses the init window, later ones the operating one
            busy_reg <= 1'b1;
            is_long_reg <= 1'b1;
            count_reg <= init_done_reg ? `OPER_CAL_CYCLES : `INIT_CAL_CYCLES;
        end else if (short_cal) begin
            busy_reg <= 1'b1;
            is_long_reg <= 1'b0;
            count_reg <= `SHORT_CAL_CYCLES;
        end
    end else begin
        count_reg <= count_reg - 1'b1;
        if (count_reg == 10'h001) begin
            busy_reg <= 1'b0;
            if (is_long_reg) begin
                ron_reg <= target_ron;
                rtt_reg <= target_rtt;
                init_done_reg <= 1'b1;
            end else begin
                // One code step is at least the minimum correction
                ron_reg <= step_toward(ron_reg, target_ron);
                rtt_reg <= step_toward(rtt_reg, target_rtt);
            end
        end
    end
end

endmodule // impedance_calibrator

// ### sdram_command_bank_logic.v
/*
 * Command decoder, bank state, burst engine, refresh counter and calibration
 * for a low-voltage synchronous DRAM seen from its command bus.
 * Assumes command, address and data inputs synchronous to core_clk; the
 * controller keeps its own timing, refresh scheduling and ordering duties.
 */
`timescale 1ns/10ps
`include "sdram_cmd_defines.vh"

// Summary of operation
// - Long calibration runs the engine, then applies new driver and termination codes.
// - Short calibration makes a reduced correction within 64 clock cycles.
// - Activate opens the addressed row in the selected bank until precharged.
// - Read bursts from an open row; start column low bits; bit ten auto-closes.
// - With on-the-fly enabled, bit twelve picks four-beat or eight-beat burst.
// - An accepted read burst completes; later commands cannot interrupt it.
// - Write addresses selected bank, bit ten auto-closes, stores burst data.
// - Byte mask low writes the byte; mask high leaves it unchanged.
// - Precharge closes one bank, or all banks when bit ten is high.
// - Precharged bank is idle and must be reactivated after precharge time.
// - Precharge of idle or precharging bank is a no-op but restarts timing.
// - During auto precharge, accesses to other banks are still accepted.
// - Refresh uses an internal row counter; one command, one refresh.
// - Commands decode from select, strobes, write enable, clock enable each edge.
// - No-operation or deselect starts nothing and stops nothing.
module sdram_command_bank_logic (
    // Clock and reset
    input wire core_clk,
    input wire rst,
    // Command bus
    input wire clock_enable,
    input wire chip_select_n,
    input wire row_strobe_n,
    input wire column_strobe_n,
    input wire write_enable_n,
    input wire [`BANK_W-1:0] bank_addr,
    input wire [`ADDR_W-1:0] addr,
    // Write data
    input wire [`DATA_W-1:0] write_data,
    input wire [`MASK_W-1:0] write_byte_mask,
    // Mode configuration
    input wire burst_otf_enable,
    input wire fixed_chop_select,
    // Calibration comparator targets
    input wire [`IMP_W-1:0] ron_target,
    input wire [`IMP_W-1:0] rtt_target,
    // Read data
    output reg [`DATA_W-1:0] read_data_reg,
    output reg read_valid_reg,
    // Status
    output reg [`NUM_BANKS-1:0] bank_open_reg,
    output reg [`NUM_BANKS-1:0] bank_precharging_reg,
    output reg burst_busy_reg,
    output reg access_error_reg,
    output reg refresh_busy_reg,
    output reg [`ROW_W-1:0] refresh_row_reg,
    output reg calibration_busy_reg,
    output reg [`IMP_W-1:0] driver_impedance_reg,
    output reg [`IMP_W-1:0] termination_impedance_reg
);

// ----------------------------------------------------------------
// Command decode
// ----------------------------------------------------------------
wire selected;
wire [2:0] cmd;
wire cmd_act;
wire cmd_read;
wire cmd_write;
wire cmd_pre;
wire cmd_ref;
wire cmd_cal;
wire auto_close;
wire burst_eight;

assign selected = clock_enable && !chip_select_n;
assign cmd = selected ? {row_strobe_n, column_strobe_n, write_enable_n} : `CMD_NOP;
assign cmd_act = (cmd == `CMD_ACTIVATE);
assign cmd_read = (cmd == `CMD_READ);
assign cmd_write = (cmd == `CMD_WRITE);
assign cmd_pre = (cmd == `CMD_PRECHARGE);
assign cmd_ref = (cmd == `CMD_REFRESH);
assign cmd_cal = (cmd == `CMD_CALIBRATE);
assign auto_close = addr[`AUTO_CLOSE_BIT];
assign burst_eight = burst_otf_enable ? addr[`BURST_SEL_BIT] : !fixed_chop_select;

// ----------------------------------------------------------------
// Bank state
// ----------------------------------------------------------------
reg burst_active_reg;
reg burst_write_reg;
reg burst_eight_reg;
reg burst_close_reg;
reg [2:0] burst_beat_reg;
reg [`BANK_W-1:0] burst_bank_reg;
reg [9:0] burst_col_reg;
wire last_beat;
wire auto_close_fire;
wire [`NUM_BANKS-1:0] open_w;
wire [`NUM_BANKS-1:0] precharging_w;
wire target_open;

assign last_beat = burst_active_reg && (burst_beat_reg == (burst_eight_reg ? 3'h7 : 3'h3));
assign auto_close_fire = last_beat && burst_close_reg;
assign target_open = open_w[bank_addr];

genvar gi;
generate
    for (gi = 0; gi < `NUM_BANKS; gi = gi + 1) begin : g_bank
        bank_tracker u_bank (
            .core_clk(core_clk),
            .rst(rst),
            .activate(cmd_act && (bank_addr == gi)),
            // All-bank close ignores the bank address
            .precharge((cmd_pre && (auto_close || bank_addr == gi)) ||
                       (auto_close_fire && burst_bank_reg == gi)),
            .row_in(addr[`ROW_W-1:0]),
            .open_reg(open_w[gi]),
            .row_reg(),
            .precharging_reg(precharging_w[gi])
        );
    end
endgenerate

// ----------------------------------------------------------------
// Burst engine and storage
// ----------------------------------------------------------------
reg [`DATA_W-1:0] mem [0:`MEM_DEPTH-1];
wire accept_access;
wire [2:0] beat_col;
wire [`BANK_W+`MEM_COL_W-1:0] mem_index;
integer bi;

// Later accesses are ignored until the burst ends
assign accept_access = (cmd_read || cmd_write) && !burst_active_reg && target_open;
// Sequential order wraps inside the chopped or full burst
assign beat_col = burst_eight_reg ? (burst_col_reg[2:0] + burst_beat_reg) :
                  {burst_col_reg[2], burst_col_reg[1:0] + burst_beat_reg[1:0]};
assign mem_index = {burst_bank_reg, burst_col_reg[`MEM_COL_W-1:3], beat_col};

always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        burst_active_reg <= 1'b0;
        burst_write_reg <= 1'b0;
        burst_eight_reg <= 1'b0;
        burst_close_reg <= 1'b0;
        burst_beat_reg <= 3'h0;
        burst_bank_reg <= {`BANK_W{1'b0}};
        burst_col_reg <= 10'h000;
    end else if (accept_access) begin
        burst_active_reg <= 1'b1;
        burst_write_reg <= cmd_write;
        burst_eight_reg <= burst_eight;
        burst_close_reg <= auto_close;
        burst_beat_reg <= 3'h0;
        burst_bank_reg <= bank_addr;
        burst_col_reg <= addr[9:0];
    end else if (burst_active_reg) begin
        burst_beat_reg <= burst_beat_reg + 1'b1;
        if (last_beat) begin
            burst_active_reg <= 1'b0;
        end
    end
end

always @(posedge core_clk) begin
    if (burst_active_reg && burst_write_reg) begin
        for (bi = 0; bi < `MASK_W; bi = bi + 1) begin
            if (!write_byte_mask[bi]) begin
                mem[mem_index][bi*8 +: 8] <= write_data[bi*8 +: 8];
            end
        end
    end
end

always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        read_data_reg <= {`DATA_W{1'b0}};
        read_valid_reg <= 1'b0;
    end else begin
        read_valid_reg <= burst_active_reg && !burst_write_reg;
        if (burst_active_reg && !burst_write_reg) begin
            read_data_reg <= mem[mem_index];
        end
    end
end

// ----------------------------------------------------------------
// Refresh
// ----------------------------------------------------------------
reg [`TIMER_W-1:0] refresh_timer_reg;
wire [31:0] refresh_count;

assign refresh_count = `REFRESH_CYCLES;

always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        refresh_busy_reg <= 1'b0;
        refresh_timer_reg <= {`TIMER_W{1'b0}};
        refresh_row_reg <= {`ROW_W{1'b0}};
    end else if (cmd_ref && !refresh_busy_reg) begin
        // Address inputs are ignored; one refresh per command
        refresh_busy_reg <= 1'b1;
        refresh_timer_reg <= refresh_count[`TIMER_W-1:0];
        refresh_row_reg <= refresh_row_reg + 1'b1;
    end else if (refresh_busy_reg) begin
        refresh_timer_reg <= refresh_timer_reg - 1'b1;
        if (refresh_timer_reg == {{(`TIMER_W-1){1'b0}}, 1'b1}) begin
            refresh_busy_reg <= 1'b0;
        end
    end
end

// ----------------------------------------------------------------
// Impedance calibration
// ----------------------------------------------------------------
wire cal_busy_w;
wire [`IMP_W-1:0] ron_w;
wire [`IMP_W-1:0] rtt_w;

impedance_calibrator u_cal (
    .core_clk(core_clk),
    .rst(rst),
    .long_cal(cmd_cal && auto_close),
    .short_cal(cmd_cal && !auto_close),
    .target_ron(ron_target),
    .target_rtt(rtt_target),
    .busy_reg(cal_busy_w),
    .ron_reg(ron_w),
    .rtt_reg(rtt_w)
);

// ----------------------------------------------------------------
// Status outputs
// ----------------------------------------------------------------
always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        bank_open_reg <= {`NUM_BANKS{1'b0}};
        bank_precharging_reg <= {`NUM_BANKS{1'b0}};
        burst_busy_reg <= 1'b0;
        access_error_reg <= 1'b0;
        calibration_busy_reg <= 1'b0;
        driver_impedance_reg <= `RON_RESET;
        termination_impedance_reg <= `RTT_RESET;
    end else begin
        bank_open_reg <= open_w;
        bank_precharging_reg <= precharging_w;
        burst_busy_reg <= burst_active_reg;
        // Access to an idle bank, or overlapping a running burst
        access_error_reg <= (cmd_read || cmd_write) && (!target_open || burst_active_reg);
        calibration_busy_reg <= cal_busy_w;
        driver_impedance_reg <= ron_w;
        termination_impedance_reg <= rtt_w;
    end
end

endmodule // sdram_command_bank_logic

// ### sdram_cmd_checker.sv
/* Assertions on the ports of the command and bank logic.
   Assumes it is bound to sdram_command_bank_logic. */
`timescale 1ns/10ps
`include "sdram_cmd_defines.vh"

module sdram_cmd_checker (
    // Clock and reset
    input wire core_clk,
    input wire rst,
    // Command bus
    input wire clock_enable,
    input wire chip_select_n,
    input wire row_strobe_n,
    input wire column_strobe_n,
    input wire write_enable_n,
    input wire [`ADDR_W-1:0] addr,
    // Status
    input wire read_valid_reg,
    input wire [`NUM_BANKS-1:0] bank_open_reg,
    input wire burst_busy_reg,
    input wire access_error_reg,
    input wire refresh_busy_reg,
    input wire [`ROW_W-1:0] refresh_row_reg,
    input wire calibration_busy_reg,
    input wire [`IMP_W-1:0] driver_impedance_reg
);
// ----------------------------------------------------------------
// Command decode
// ----------------------------------------------------------------
wire taken = clock_enable && !chip_select_n;
wire [2:0] cmd = {row_strobe_n, column_strobe_n, write_enable_n};
wire is_act = taken && cmd == `CMD_ACTIVATE;
wire is_pre = taken && cmd == `CMD_PRECHARGE;
wire is_rw = taken && (cmd == `CMD_READ || cmd == `CMD_WRITE);
wire is_ref = taken && cmd == `CMD_REFRESH;
wire is_cal = taken && cmd == `CMD_CALIBRATE;

// ----------------------------------------------------------------
// Properties
// ----------------------------------------------------------------
default clocking @(posedge core_clk);
endclocking
default disable iff (rst);

sequence s_short_start;
    is_cal && !addr[`AUTO_CLOSE_BIT] && !calibration_busy_reg && !$past(is_cal);
endsequence
sequence s_short_run;
    ##[1:2] calibration_busy_reg ##[1:64] !calibration_busy_reg;
endsequence

property p_open_cause;
    (bank_open_reg & ~$past(bank_open_reg)) != 8'h00 |-> $past(is_act, 2) || $past(is_act, 3);
endproperty
property p_pre_all;
    is_pre && addr[`AUTO_CLOSE_BIT] |-> ##3 bank_open_reg == 8'h00;
endproperty
property p_beats;
    $rose(read_valid_reg) |-> read_valid_reg [*4];
endproperty
property p_busy;
    read_valid_reg |-> burst_busy_reg;
endproperty
property p_err;
    $rose(access_error_reg) |-> $past(is_rw) || $past(is_rw, 2);
endproperty
property p_ref_row;
    is_ref && !refresh_busy_reg |=> refresh_row_reg == $past(refresh_row_reg) + 16'h0001;
endproperty
property p_ref_busy;
    $rose(refresh_busy_reg) |-> refresh_busy_reg [*8];
endproperty
property p_cal_codes;
    $changed(driver_impedance_reg) |-> calibration_busy_reg || $past(calibration_busy_reg);
endproperty
property p_short;
    s_short_start |-> s_short_run;
endproperty

a_open_cause: assert property (p_open_cause) else $error("bank opened without activate");
a_pre_all: assert property (p_pre_all) else $error("banks open after all-bank precharge");
a_beats: assert property (p_beats) else $error("read burst shorter than four beats");
a_busy: assert property (p_busy) else $error("read beat outside burst");
a_err: assert property (p_err) else $error("access error without access");
a_ref_row: assert property (p_ref_row) else $error("refresh counter did not step");
a_ref_busy: assert property (p_ref_busy) else $error("refresh period too short");
a_cal_codes: assert property (p_cal_codes) else $error("codes changed outside calibration");
a_short: assert property (p_short) else $error("short calibration overran");
endmodule // sdram_cmd_checker

bind sdram_command_bank_logic sdram_cmd_checker i_sdram_cmd_checker (.core_clk, .rst, .clock_enable,
    .chip_select_n, .row_strobe_n, .column_strobe_n, .write_enable_n, .addr, .read_valid_reg, .bank_open_reg,
    .burst_busy_reg, .access_error_reg, .refresh_busy_reg, .refresh_row_reg, .calibration_busy_reg,
    .driver_impedance_reg);

// ### mem_ctrl_model.sv
/* Memory controller model driving the command bus and write data.
   Assumes callers start each task just after a rising edge. */
`timescale 1ns/10ps
`include "sdram_cmd_defines.vh"

module mem_ctrl_model (
    // Clock
    input wire core_clk,
    // Command bus
    output logic clock_enable = 1'b1,
    output logic chip_select_n = 1'b1,
    output logic row_strobe_n = 1'b1,
    output logic column_strobe_n = 1'b1,
    output logic write_enable_n = 1'b1,
    output logic [2:0] bank_addr = 3'h0,
    output logic [15:0] addr = 16'h0000,
    // Write data
    output logic [15:0] write_data = 16'h0000,
    output logic [1:0] write_byte_mask = 2'h0
);
// Leaves the command standing so a following command can replace it
task hold_cmd(input [2:0] c, input [2:0] b, input [15:0] a);
    chip_select_n = 1'b0;
    {row_strobe_n, column_strobe_n, write_enable_n} = c;
    bank_addr = b;
    addr = a;
    @(posedge core_clk);
    #1;
endtask

task send(input [2:0] c, input [2:0] b, input [15:0] a);
    hold_cmd(c, b, a);
    chip_select_n = 1'b1;
    {row_strobe_n, column_strobe_n, write_enable_n} = 3'h7;
    bank_addr = ~b;
    addr = ~a;
endtask

task beat(input [15:0] d, input [1:0] m);
    write_data = d;
    write_byte_mask = m;
    @(posedge core_clk);
    #1;
endtask

// Drives the inverted data and mask after the last beat
task rest_data;
    write_data = ~write_data;
    write_byte_mask = ~write_byte_mask;
endtask

// Refreshes go out back to back, far inside rate and posting limits
// Self refresh is never entered, so no posting carries over

task refresh;
    send(`CMD_PRECHARGE, 3'h0, 16'h0400);
    repeat (`PRECHARGE_CYCLES) @(posedge core_clk);
    #1;
    send(`CMD_REFRESH, 3'h2, 16'h5a5a);
    repeat (`REFRESH_CYCLES) @(posedge core_clk);
    #1;
endtask
endmodule // mem_ctrl_model

// ### test_sdram_command_bank_logic.sv
/* Self-checking bench for the command and bank logic.
   Assumes the controller model and the bound checker. */
`timescale 1ns/10ps
`include "sdram_cmd_defines.vh"

module test_sdram_command_bank_logic;
logic core_clk = 1'b0;
logic rst = 1'b1;
logic burst_otf_enable = 1'b1;
logic fixed_chop_select = 1'b0;
logic [5:0] ron_target = 6'h25;
logic [5:0] rtt_target = 6'h1b;
wire clock_enable, chip_select_n, row_strobe_n, column_strobe_n, write_enable_n;
wire [2:0] bank_addr;
wire [15:0] addr, write_data, read_data_reg, refresh_row_reg;
wire [1:0] write_byte_mask;
wire read_valid_reg, burst_busy_reg, access_error_reg, refresh_busy_reg, calibration_busy_reg;
wire [7:0] bank_open_reg, bank_precharging_reg;
wire [5:0] driver_impedance_reg, termination_impedance_reg;
int miscompares = 0;
int n_compared = 0;
int k, cnt;
logic err_seen;

always #4 core_clk = ~core_clk;

mem_ctrl_model i_mem_ctrl_model (.core_clk, .clock_enable, .chip_select_n, .row_strobe_n, .column_strobe_n,
    .write_enable_n, .bank_addr, .addr, .write_data, .write_byte_mask);
sdram_command_bank_logic i_sdram_command_bank_logic (.core_clk, .rst, .clock_enable, .chip_select_n,
    .row_strobe_n, .column_strobe_n, .write_enable_n, .bank_addr, .addr, .write_data, .write_byte_mask,
    .burst_otf_enable, .fixed_chop_select, .ron_target, .rtt_target, .read_data_reg, .read_valid_reg,
    .bank_open_reg, .bank_precharging_reg, .burst_busy_reg, .access_error_reg, .refresh_busy_reg,
    .refresh_row_reg, .calibration_busy_reg, .driver_impedance_reg, .termination_impedance_reg);

// ----------------------------------------------------------------
// Tasks
// ----------------------------------------------------------------
task step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
endtask

task check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
        miscompares++;
        $display("Error %s expected %h seen %h", what, exp, got);
    end
endtask

function logic [15:0] exp_word(input int c);
    return (c < 4) ? 16'ha000 + c[15:0] : 16'hbb00 + c[15:0];
endfunction

task read_burst(input [2:0] b, input [15:0] a, input int n, input bit intr);
    int c;
    if (intr) begin
        // Second read lands inside the first burst and must be refused
        i_mem_ctrl_model.hold_cmd(`CMD_READ, b, a);
        i_mem_ctrl_model.send(`CMD_READ, b, 16'h1000);
    end else begin
        i_mem_ctrl_model.send(`CMD_READ, b, a);
    end
    err_seen = 1'b0;
    for (c = 0; c < 4 && read_valid_reg !== 1'b1; c++) step(1);
    for (int j = 0; j < n; j++) begin
        c = (a[2:0] & ~(n - 1)) | ((a[2:0] + j) & (n - 1));
        check_val("read beat", exp_word(c), read_data_reg);
        if (access_error_reg === 1'b1) err_seen = 1'b1;
        step(1);
    end
    check_val("valid after burst", 16'h0000, {15'h0000, read_valid_reg});
endtask

task cal_run(input [15:0] a);
    i_mem_ctrl_model.send(`CMD_CALIBRATE, 3'h0, a);
    for (k = 0; k < 4 && calibration_busy_reg !== 1'b1; k++) step(1);
    for (cnt = 0; cnt < 700 && calibration_busy_reg === 1'b1; cnt++) step(1);
endtask

task print_verdict;
    $display("Compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
        $display("SIMULATION PASSED");
    end else begin
        $display("SIMULATION FAILED");
    end
    $finish;
endtask

// ----------------------------------------------------------------
// Tests
// ----------------------------------------------------------------
initial begin
    #(8 * 4000);
    miscompares++;
    print_verdict;
end

initial begin
    step(3);
    rst = 1'b0;
    check_val("driver code", 16'h0020, {10'h000, driver_impedance_reg});
    check_val("open banks", 16'h0000, {8'h00, bank_open_reg});
    $display("Test reset done");
    i_mem_ctrl_model.hold_cmd(`CMD_ACTIVATE, 3'h3, 16'h1234);
    i_mem_ctrl_model.send(`CMD_ACTIVATE, 3'h5, 16'h0042);
    step(2);
    check_val("open banks", 16'h0028, {8'h00, bank_open_reg});
    $display("Test activate done");
    i_mem_ctrl_model.send(`CMD_WRITE, 3'h3, 16'h1000);
    for (k = 0; k < 8; k++) i_mem_ctrl_model.beat(16'ha000 + k[15:0], 2'h0);
    i_mem_ctrl_model.rest_data();
    i_mem_ctrl_model.send(`CMD_WRITE, 3'h3, 16'h0004);
    for (k = 0; k < 4; k++) i_mem_ctrl_model.beat(16'hbbff, 2'h1);
    i_mem_ctrl_model.rest_data();
    read_burst(3'h3, 16'h1002, 8, 1'b1);
    check_val("refused read flagged", 16'h0001, {15'h0000, err_seen});
    // Fixed chop from the mode inputs overrides bit twelve
    burst_otf_enable = 1'b0;
    fixed_chop_select = 1'b1;
    read_burst(3'h3, 16'h1000, 4, 1'b0);
    burst_otf_enable = 1'b1;
    read_burst(3'h3, 16'h0405, 4, 1'b0);
    step(2);
    check_val("auto closed bank", 16'h0020, {8'h00, bank_open_reg});
    $display("Test bursts done");
    i_mem_ctrl_model.hold_cmd(`CMD_ACTIVATE, 3'h0, 16'h0777);
    i_mem_ctrl_model.hold_cmd(`CMD_PRECHARGE, 3'h3, 16'h0000);
    i_mem_ctrl_model.send(`CMD_PRECHARGE, 3'h0, 16'h0000);
    // Idle bank 3 still restarted its precharge timer
    check_val("precharging banks", 16'h0008, {8'h00, bank_precharging_reg});
    step(3);
    check_val("single bank closed", 16'h0020, {8'h00, bank_open_reg});
    i_mem_ctrl_model.send(`CMD_PRECHARGE, 3'h0, 16'h0400);
    step(3);
    check_val("all banks closed", 16'h0000, {8'h00, bank_open_reg});
    i_mem_ctrl_model.send(`CMD_READ, 3'h5, 16'h0000);
    err_seen = 1'b0;
    for (k = 0; k < 4; k++) begin
        if (access_error_reg === 1'b1) err_seen = 1'b1;
        step(1);
    end
    check_val("read to idle bank", 16'h0001, {15'h0000, err_seen});
    // Precharged bank takes a different row
    i_mem_ctrl_model.send(`CMD_ACTIVATE, 3'h3, 16'h0555);
    step(2);
    check_val("reopened bank", 16'h0008, {8'h00, bank_open_reg});
    $display("Test precharge done");
    i_mem_ctrl_model.refresh();
    check_val("refresh row", 16'h0001, refresh_row_reg);
    i_mem_ctrl_model.refresh();
    check_val("refresh row", 16'h0002, refresh_row_reg);
    check_val("refresh busy", 16'h0000, {15'h0000, refresh_busy_reg});
    $display("Test refresh done");
    cal_run(16'h0000);
    check_val("short span", 16'h0001, {15'h0000, cnt <= 64});
    check_val("driver code", 16'h0021, {10'h000, driver_impedance_reg});
    check_val("termination code", 16'h001f, {10'h000, termination_impedance_reg});
    cal_run(16'h0400);
    check_val("long span", 16'h0001, {15'h0000, cnt <= 512});
    check_val("driver code", 16'h0025, {10'h000, driver_impedance_reg});
    check_val("termination code", 16'h001b, {10'h000, termination_impedance_reg});
    $display("Test calibration done");
    print_verdict;
end
endmodule // test_sdram_command_bank_logic
